// [rtl/ipr_interrupt_priority_regs.sv]
// Local design decisions: register access over AHB-Lite and the register offsets.
`default_nettype none
module ipr_interrupt_priority_regs (
	input  wire logic                                                   core_clk,
	input  wire logic                                                   rst_n,
	input  wire logic                                                   hsel,
	input  wire logic [7:0]                                             haddr,
	input  wire logic [1:0]                                             htrans,
	input  wire logic                                                   hwrite,
	input  wire logic [2:0]                                             hsize,
	input  wire logic                                                   hready,
	input  wire logic [31:0]                                            hwdata,
	output logic      [31:0]                                            hrdata,
	output logic                                                        hreadyout,
	output logic                                                        hresp,
	output logic      [ipr_pkg::IPR_NUM_SRC*ipr_pkg::IPR_PRIO_W-1:0]    srcPrio,
	output logic      [ipr_pkg::IPR_NUM_SRC-1:0]                        srcEnable
);
	localparam int NSRC = ipr_pkg::IPR_NUM_SRC;
	localparam int PW   = ipr_pkg::IPR_PRIO_W;

	// The word decode serves at most seven words, and the bypass mask is built from three-bit fields.
	// A wider field or a longer bank would need a new decode rather than a changed constant.
	if (ipr_pkg::IPR_NUM_REGS > 7 || PW != 3) begin : g_bad_cfg
		$error("register count or field width not served by this bank");
	end

	// A field that reaches past bit 15 or into a missing word would be lost from the read view.
	for (genvar s = 0; s < NSRC; s++) begin : g_place_chk
		if (ipr_pkg::IPR_SRC_REG[s] >= ipr_pkg::IPR_NUM_REGS || ipr_pkg::IPR_SRC_POS[s] + PW > 16) begin : g_bad
			$error("priority field placed outside its register");
		end
	end

	ipr_pkg::ipr_addr_phase_t addrPhase_ff;
	logic [31:0]              hrdata_ff;
	logic [PW-1:0]            fieldPrio  [NSRC];
	logic [NSRC-1:0]          fieldEn;
	logic [NSRC*PW-1:0]       srcPrio_ff;
	logic [NSRC-1:0]          srcEnable_ff;
	logic [15:0]              regView    [ipr_pkg::IPR_NUM_REGS];
	logic [15:0]              nxt_rdata;
	logic                     addrMapped;
	logic [2:0]               addrIndex;
	logic                     wrCommit;
	logic                     rdTaken;

	// Decode the word address; anything beyond the seven words is unmapped.
	always_comb begin
		addrIndex  = haddr[4:2];
		addrMapped = (haddr[1:0] == 2'h0) && (haddr[7:5] == 3'h0) && (haddr[4:2] != 3'h7);
	end

	// Capture the address phase of a NONSEQ or SEQ transfer; IDLE and BUSY leave no data phase.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			addrPhase_ff <= '0;
		end else if (hready) begin
			addrPhase_ff.valid  <= hsel && htrans[1];
			addrPhase_ff.write  <= hwrite;
			addrPhase_ff.index  <= addrIndex;
			addrPhase_ff.mapped <= addrMapped;
		end
	end

	// Writes land in the data phase, so hwdata is only sampled then.
	assign wrCommit = addrPhase_ff.valid && addrPhase_ff.write && addrPhase_ff.mapped;

	// A read is taken whenever a selected NONSEQ or SEQ read address phase meets hready.
	assign rdTaken = hready && hsel && htrans[1] && !hwrite;

	// One field instance per source, placed by the package's index and position tables.
	for (genvar s = 0; s < NSRC; s++) begin : g_field
		localparam int REG = ipr_pkg::IPR_SRC_REG[s];
		localparam int POS = ipr_pkg::IPR_SRC_POS[s];
		ipr_prio_field u_field (
			.core_clk   (core_clk),
			.rst_n      (rst_n),
			.wrEn       (wrCommit && (addrPhase_ff.index == 3'(REG))),
			.wrData     (hwdata[POS+PW-1:POS]),
			.prio       (fieldPrio[s]),
			.srcEnabled (fieldEn[s])
		);
	end

	// Read view of each register; unlisted bits are constant zero so writes there vanish.
	always_comb begin
		for (int r = 0; r < ipr_pkg::IPR_NUM_REGS; r++) begin
			regView[r] = 16'h0000;
		end
		for (int s = 0; s < NSRC; s++) begin
			regView[ipr_pkg::IPR_SRC_REG[s]][ipr_pkg::IPR_SRC_POS[s] +: PW] = fieldPrio[s];
		end
	end

	// Read mux for the current address phase; an unmapped word reads zero.
	always_comb begin
		nxt_rdata = 16'h0000;
		if (addrMapped) begin
			nxt_rdata = regView[addrIndex];
		end
	end

	// Read data is registered at the address phase so hrdata comes from a flop.
	// A read right after a write to the same word would see the old value, so that case
	// bypasses the write data into the read path.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata_ff <= 32'h0000_0000;
		end else if (rdTaken) begin
			if (wrCommit && addrPhase_ff.index == addrIndex && addrMapped) begin
				hrdata_ff <= {16'h0000, bypassView(addrIndex, hwdata[15:0])};
			end else begin
				hrdata_ff <= {16'h0000, nxt_rdata};
			end
		end
	end

	// Masks a raw write word down to the implemented bits of register r.
	function automatic logic [15:0] bypassView(input logic [2:0] r, input logic [15:0] w);
		logic [15:0] m;
		m = 16'h0000;
		for (int s = 0; s < NSRC; s++) begin
			if (3'(ipr_pkg::IPR_SRC_REG[s]) == r) begin
				m[ipr_pkg::IPR_SRC_POS[s] +: PW] = 3'h7;
			end
		end
		return w & m;
	endfunction

	// Priorities and enables for the arbiter, one cycle after the write lands.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			srcPrio_ff   <= {NSRC{ipr_pkg::IPR_PRIO_RESET}};
			srcEnable_ff <= '1;
		end else begin
			for (int s = 0; s < NSRC; s++) begin
				srcPrio_ff[s*PW +: PW] <= fieldPrio[s];
			end
			srcEnable_ff <= fieldEn;
		end
	end

	assign hrdata    = hrdata_ff;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign srcPrio   = srcPrio_ff;
	assign srcEnable = srcEnable_ff;

	// Checks.
	AST_DISABLED_NO_ENABLE: assert property (@(posedge core_clk) disable iff (!rst_n)
		srcEnable[0] == (srcPrio[2:0] != 3'h0))
		else $error("disabled source still enabled");
	AST_RESET_LEVEL_FOUR: assert property (@(posedge core_clk)
		$rose(rst_n) |-> (srcPrio[2:0] == 3'h4) && (srcPrio[41:39] == 3'h4))
		else $error("source not at level four after reset");
	AST_WRITE_VISIBLE: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrCommit && addrPhase_ff.index == 3'h0 |-> ##2 srcPrio[11:9] == $past(hwdata[2:0], 2))
		else $error("timer5 level not updated after write");
	AST_UART2_TX_POS: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrCommit && addrPhase_ff.index == 3'h0 |=> fieldPrio[0] == $past(hwdata[14:12]))
		else $error("uart2 tx field misplaced");
	AST_SPI2_EVENT_POS: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrCommit && addrPhase_ff.index == 3'h1 |=> fieldPrio[4] == $past(hwdata[6:4]))
		else $error("spi2 event field misplaced");
	AST_CAPTURE5_POS: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrCommit && addrPhase_ff.index == 3'h2 |=> fieldPrio[6] == $past(hwdata[14:12]))
		else $error("capture5 field misplaced");
	AST_RTC_POS: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrCommit && addrPhase_ff.index == 3'h6 |=> fieldPrio[13] == $past(hwdata[10:8]))
		else $error("rtc field misplaced");
	AST_UPPER_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
		hrdata[31:15] == 17'h0 && hrdata[11] == 1'b0 && hrdata[7] == 1'b0 && hrdata[3] == 1'b0)
		else $error("unimplemented read bits not zero");
	AST_OTHER_REG_KEEP: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrCommit && addrPhase_ff.index != 3'h3 |=> $stable(fieldPrio[9]))
		else $error("compare5 changed by a foreign write");

	// Each remaining field lands at its own bit position one edge after its write data phase.
	AST_UART2_RX_POS: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrCommit && addrPhase_ff.index == 3'h0 |=> fieldPrio[1] == $past(hwdata[10:8]))
		else $error("uart2 rx field misplaced");
	AST_EXT_IRQ2_POS: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrCommit && addrPhase_ff.index == 3'h0 |=> fieldPrio[2] == $past(hwdata[6:4]))
		else $error("ext irq2 field misplaced");
	AST_TIMER5_POS: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrCommit && addrPhase_ff.index == 3'h0 |=> fieldPrio[3] == $past(hwdata[2:0]))
		else $error("timer5 field misplaced");
	AST_SPI2_FAULT_POS: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrCommit && addrPhase_ff.index == 3'h1 |=> fieldPrio[5] == $past(hwdata[2:0]))
		else $error("spi2 fault field misplaced");
	AST_CAPTURE4_POS: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrCommit && addrPhase_ff.index == 3'h2 |=> fieldPrio[7] == $past(hwdata[10:8]))
		else $error("capture4 field misplaced");
	AST_CAPTURE3_POS: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrCommit && addrPhase_ff.index == 3'h2 |=> fieldPrio[8] == $past(hwdata[6:4]))
		else $error("capture3 field misplaced");
	AST_COMPARE5_POS: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrCommit && addrPhase_ff.index == 3'h3 |=> fieldPrio[9] == $past(hwdata[6:4]))
		else $error("compare5 field misplaced");
	AST_PARALLEL_PORT_POS: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrCommit && addrPhase_ff.index == 3'h4 |=> fieldPrio[10] == $past(hwdata[6:4]))
		else $error("parallel port field misplaced");
	AST_I2C2_MASTER_POS: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrCommit && addrPhase_ff.index == 3'h5 |=> fieldPrio[11] == $past(hwdata[10:8]))
		else $error("i2c2 master field misplaced");
	AST_I2C2_SLAVE_POS: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrCommit && addrPhase_ff.index == 3'h5 |=> fieldPrio[12] == $past(hwdata[6:4]))
		else $error("i2c2 slave field misplaced");

	// Unimplemented positions of each word read zero whatever was written there.
	AST_SPI2_READ_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
		rdTaken && addrMapped && addrIndex == 3'h1 |=> hrdata[15:7] == 9'h000 && hrdata[3] == 1'b0)
		else $error("spi2 word shows unimplemented bits");
	AST_CAPTURE_READ_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
		rdTaken && addrMapped && addrIndex == 3'h2 |=> hrdata[3:0] == 4'h0)
		else $error("capture word shows unimplemented bits");
	AST_COMPARE5_READ_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
		rdTaken && addrMapped && addrIndex == 3'h3 |=> hrdata[15:7] == 9'h000 && hrdata[3:0] == 4'h0)
		else $error("compare5 word shows unimplemented bits");
	AST_PARALLEL_READ_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
		rdTaken && addrMapped && addrIndex == 3'h4 |=> hrdata[15:7] == 9'h000 && hrdata[3:0] == 4'h0)
		else $error("parallel port word shows unimplemented bits");
	AST_I2C2_READ_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
		rdTaken && addrMapped && addrIndex == 3'h5 |=> hrdata[15:11] == 5'h00 && hrdata[3:0] == 4'h0)
		else $error("i2c2 word shows unimplemented bits");
	AST_RTC_READ_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
		rdTaken && addrMapped && addrIndex == 3'h6 |=> hrdata[15:11] == 5'h00 && hrdata[7:0] == 8'h00)
		else $error("rtc word shows unimplemented bits");
	AST_UNMAPPED_READ_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
		rdTaken && !addrMapped |=> hrdata == 32'h0000_0000)
		else $error("unmapped word does not read zero");

	// Writes to missing words and reads of any word leave the fields alone.
	AST_UNMAPPED_WRITE_KEEP: assert property (@(posedge core_clk) disable iff (!rst_n)
		addrPhase_ff.valid && addrPhase_ff.write && !addrPhase_ff.mapped |=> $stable(fieldPrio[0]) && $stable(fieldPrio[13]))
		else $error("unmapped write changed a field");
	AST_READ_KEEP: assert property (@(posedge core_clk) disable iff (!rst_n)
		addrPhase_ff.valid && !addrPhase_ff.write |=> $stable(fieldPrio[3]) && $stable(fieldPrio[10]))
		else $error("read changed a field");

	// The arbiter sees each field one edge after the field, and the code is the level itself.
	AST_LEVEL_FOLLOWS: assert property (@(posedge core_clk) disable iff (!rst_n)
		$past(rst_n) |-> srcPrio[41:39] == $past(fieldPrio[13]) && srcPrio[17:15] == $past(fieldPrio[5]))
		else $error("source level does not follow its field");
	AST_RTC_DISABLED: assert property (@(posedge core_clk) disable iff (!rst_n)
		srcEnable[13] == (srcPrio[41:39] != 3'h0))
		else $error("disabled rtc source still enabled");
	AST_MAX_IS_SEVEN: assert property (@(posedge core_clk) disable iff (!rst_n)
		fieldPrio[0] == 3'h7 |=> srcPrio[2:0] == 3'h7 && srcEnable[0])
		else $error("all-ones code is not level seven");
	AST_ONE_IS_LOWEST: assert property (@(posedge core_clk) disable iff (!rst_n)
		fieldPrio[3] == 3'h1 |=> srcPrio[11:9] == 3'h1 && srcEnable[3])
		else $error("code one is not level one");

	// Reset puts every source at level four, and read data stands until the next read is taken.
	AST_RESET_ALL_FOUR: assert property (@(posedge core_clk)
		$rose(rst_n) |-> srcPrio == {NSRC{ipr_pkg::IPR_PRIO_RESET}} && (&srcEnable))
		else $error("not every source at level four after reset");
	AST_READ_STANDS: assert property (@(posedge core_clk) disable iff (!rst_n)
		!rdTaken |=> $stable(hrdata))
		else $error("read data changed without a read");

	// A write to one word leaves the fields of every other word unchanged.
	AST_TIMER5_KEEP: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrCommit && addrPhase_ff.index != 3'h0 |=> $stable(fieldPrio[3]))
		else $error("timer5 changed by a foreign write");
	AST_SPI2_KEEP: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrCommit && addrPhase_ff.index != 3'h1 |=> $stable(fieldPrio[5]))
		else $error("spi2 fault changed by a foreign write");
	AST_CAPTURE_KEEP: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrCommit && addrPhase_ff.index != 3'h2 |=> $stable(fieldPrio[6]))
		else $error("capture5 changed by a foreign write");
	AST_PARALLEL_KEEP: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrCommit && addrPhase_ff.index != 3'h4 |=> $stable(fieldPrio[10]))
		else $error("parallel port changed by a foreign write");
	AST_I2C2_KEEP: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrCommit && addrPhase_ff.index != 3'h5 |=> $stable(fieldPrio[11]))
		else $error("i2c2 master changed by a foreign write");
	AST_RTC_KEEP: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrCommit && addrPhase_ff.index != 3'h6 |=> $stable(fieldPrio[13]))
		else $error("rtc changed by a foreign write");

	// Main scenarios that the tests are expected to reach.
	COV_WRITE: cover property (@(posedge core_clk) disable iff (!rst_n) wrCommit);
	COV_DISABLE: cover property (@(posedge core_clk) disable iff (!rst_n) !srcEnable[13]);
	COV_MAX: cover property (@(posedge core_clk) disable iff (!rst_n) srcPrio[2:0] == 3'h7);
	COV_UNMAPPED: cover property (@(posedge core_clk) disable iff (!rst_n) rdTaken && !addrMapped);
	COV_RTC_READ: cover property (@(posedge core_clk) disable iff (!rst_n) rdTaken && addrMapped && addrIndex == 3'h6);
endmodule
`default_nettype wire

// [rtl/ipr_pkg.sv]
`default_nettype none
package ipr_pkg;
	// Register word offsets (byte addresses), one aligned word each.
	localparam logic [7:0] IPR_OFF_UART2_EXT2_TIMER5 = 8'h00;
	localparam logic [7:0] IPR_OFF_SPI2              = 8'h04;
	localparam logic [7:0] IPR_OFF_CAPTURE           = 8'h08;
	localparam logic [7:0] IPR_OFF_COMPARE5          = 8'h0C;
	localparam logic [7:0] IPR_OFF_PARALLEL_PORT     = 8'h10;
	localparam logic [7:0] IPR_OFF_I2C2              = 8'h14;
	localparam logic [7:0] IPR_OFF_RTC               = 8'h18;
	localparam int         IPR_NUM_REGS              = 7;
	localparam int         IPR_NUM_SRC               = 14;
	localparam int         IPR_PRIO_W                = 3;

	// Field low-bit positions inside a 16-bit register.
	localparam int IPR_POS_HI  = 12;
	localparam int IPR_POS_MH  = 8;
	localparam int IPR_POS_ML  = 4;
	localparam int IPR_POS_LO  = 0;

	// Priority codes.
	localparam logic [2:0] IPR_PRIO_RESET   = 3'h4;
	localparam logic [2:0] IPR_PRIO_DISABLE = 3'h0;
	localparam logic [2:0] IPR_PRIO_MAX     = 3'h7;

	// Source index order of the priority vector.
	typedef enum int {
		IPR_SRC_UART2_TX, IPR_SRC_UART2_RX, IPR_SRC_EXT_IRQ2, IPR_SRC_TIMER5,
		IPR_SRC_SPI2_EVENT, IPR_SRC_SPI2_FAULT, IPR_SRC_CAPTURE5, IPR_SRC_CAPTURE4,
		IPR_SRC_CAPTURE3, IPR_SRC_COMPARE5, IPR_SRC_PARALLEL_PORT, IPR_SRC_I2C2_MASTER,
		IPR_SRC_I2C2_SLAVE, IPR_SRC_RTC_CALENDAR
	} ipr_src_t;

	// Register index and low bit for each source, in source order.
	localparam int IPR_SRC_REG [IPR_NUM_SRC] = '{0, 0, 0, 0, 1, 1, 2, 2, 2, 3, 4, 5, 5, 6};
	localparam int IPR_SRC_POS [IPR_NUM_SRC] = '{IPR_POS_HI, IPR_POS_MH, IPR_POS_ML, IPR_POS_LO,
		IPR_POS_ML, IPR_POS_LO, IPR_POS_HI, IPR_POS_MH, IPR_POS_ML, IPR_POS_ML, IPR_POS_ML,
		IPR_POS_MH, IPR_POS_ML, IPR_POS_MH};

	// Latched AHB-Lite address phase.
	typedef struct packed {
		logic       write;
		logic       valid;
		logic [2:0] index;
		logic       mapped;
	} ipr_addr_phase_t;
endpackage
`default_nettype wire

// [rtl/ipr_prio_field.sv]
`default_nettype none
// One three-bit priority field with its reset value and a decoded enable.
module ipr_prio_field (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       wrEn,
	input  wire logic [2:0] wrData,
	output logic      [2:0] prio,
	output logic            srcEnabled
);
	logic [2:0] prio_ff;

	// Field loads 100 at reset so every source starts at level four.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prio_ff <= ipr_pkg::IPR_PRIO_RESET;
		end else if (wrEn) begin
			prio_ff <= wrData;
		end
	end

	// The code is the level itself; zero means the source is disabled.
	assign prio       = prio_ff;
	assign srcEnabled = (prio_ff != ipr_pkg::IPR_PRIO_DISABLE);
endmodule
`default_nettype wire

// [testbench/ipr_interrupt_priority_regs_tb.sv]
`default_nettype none
module ipr_interrupt_priority_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// Implemented field bits of each register; every other bit must read as zero.
	localparam logic [15:0] FIELD_MASK [7] = '{16'h7777, 16'h0077, 16'h7770, 16'h0070, 16'h0070, 16'h0770, 16'h0700};

	logic        coreClk;
	logic        rstN;
	logic        hsel;
	logic        hwrite;
	logic        hready;
	logic        hreadyout;
	logic        hresp;
	logic        rdySample;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] rdSample;
	logic [31:0] rdWord;
	logic [41:0] srcPrio;
	logic [13:0] srcEnable;
	logic [15:0] shadow [7];
	int          failCount;
	int          testsRun;

	// The single slave drives the bus ready.
	assign hready = hreadyout;

	ipr_interrupt_priority_regs u_dut (
		.core_clk  (coreClk),
		.rst_n     (rstN),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hready    (hready),
		.hwdata    (hwdata),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.srcPrio   (srcPrio),
		.srcEnable (srcEnable)
	);

	// Free-running 250 MHz clock.
	initial begin
		coreClk = 1'b0;
		forever #2 coreClk = ~coreClk;
	end

	// Bus answers are captured at the sampling edge, so the tasks never race the design's own updates.
	always @(posedge coreClk) begin
		rdySample <= hready;
		rdSample <= hrdata;
	end

	task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			failCount++;
			$display("mismatch at %0t: word %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic chkLevel(input logic [3:0] got, input logic [3:0] exp);
		testsRun++;
		if (got !== exp) begin
			failCount++;
			$display("mismatch at %0t: enable and level %h, expected %h", $time, got, exp);
		end
	endtask

	// One single-word transfer; the master waits for ready in both phases and only the watchdog ends a wait.
	task automatic ahbXfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
		@(posedge coreClk);
		hsel <= 1'b1;
		haddr <= addr;
		hwrite <= wr;
		htrans <= 2'h2;
		do begin
			@(posedge coreClk);
			#1;
		end while (!rdySample);
		htrans <= 2'h0;
		hwdata <= wdata;
		do begin
			@(posedge coreClk);
			#1;
		end while (!rdySample);
		rdata = rdSample;
	endtask

	task automatic writeReg(input int r, input logic [31:0] data);
		ahbXfer(1'b1, 8'(r * 4), data, rdWord);
		shadow[r] = data[15:0] & FIELD_MASK[r];
	endtask

	// Reads every register and checks every source output against the shadow copy.
	task automatic checkAll();
		logic [2:0] lvl;
		for (int r = 0; r < 7; r++) begin
			ahbXfer(1'b0, 8'(r * 4), 32'h0, rdWord);
			chkWord(rdWord, {16'h0000, shadow[r]});
		end
		for (int s = 0; s < 14; s++) begin
			lvl = shadow[ipr_pkg::IPR_SRC_REG[s]][ipr_pkg::IPR_SRC_POS[s] +: 3];
			chkLevel({srcEnable[s], srcPrio[3 * s +: 3]}, {lvl != 3'h0, lvl});
		end
	endtask

	task automatic doReset();
		rstN <= 1'b0;
		repeat (4) @(posedge coreClk);
		rstN <= 1'b1;
		for (int r = 0; r < 7; r++) shadow[r] = FIELD_MASK[r] & 16'h4444;
	endtask

	task automatic tallyAndFinish();
		$display("counts: %0d comparisons, %0d mismatches", testsRun, failCount);
		if (failCount == 0 && testsRun > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// A hang is cut short long after the few hundred cycles the tests need.
	initial begin
		repeat (20000) @(posedge coreClk);
		failCount++;
		$display("mismatch at %0t: watchdog expired", $time);
		tallyAndFinish();
	end

	initial begin
		{hsel, hwrite, rstN, haddr, htrans, hwdata} = '0;
		hsize = 3'h2;
		failCount = 0;
		testsRun = 0;
		doReset();
		checkAll();
		$display("test reset values done");
		// Every code in every field, with bits 15, 11, 7 and 3 and the upper half set as well.
		for (int c = 0; c < 8; c++) begin
			for (int r = 0; r < 7; r++) writeReg(r, {16'hFFFF, {4{1'b1, 3'(c)}}});
			checkAll();
		end
		$display("test all codes done");
		// Unmapped places read zero, take no writes and answer OKAY.
		for (int a = 0; a < 3; a++) begin
			ahbXfer(1'b1, (a == 0) ? 8'h1C : ((a == 1) ? 8'h20 : 8'hFC), 32'hFFFFFFFF, rdWord);
			ahbXfer(1'b0, (a == 0) ? 8'h1C : ((a == 1) ? 8'h20 : 8'hFC), 32'h0, rdWord);
			chkWord(rdWord, 32'h0);
			chkWord({31'h0, hresp}, 32'h0);
		end
		checkAll();
		$display("test unmapped done");
		// A new level reaches the source output one cycle after the field takes it.
		writeReg(6, 32'h0000_0300);
		chkLevel({srcEnable[13], srcPrio[41:39]}, 4'hF);
		@(posedge coreClk);
		#1;
		chkLevel({srcEnable[13], srcPrio[41:39]}, 4'hB);
		$display("test update timing done");
		// Distinct codes per field, so a swapped or misplaced field reads back wrong.
		writeReg(0, 32'h0000_1357);
		writeReg(1, 32'h0000_0026);
		writeReg(2, 32'h0000_6420);
		writeReg(3, 32'h0000_0050);
		writeReg(4, 32'h0000_0030);
		writeReg(5, 32'h0000_0710);
		writeReg(6, 32'h0000_0200);
		checkAll();
		$display("test distinct fields done");
		doReset();
		checkAll();
		$display("test second reset done");
		tallyAndFinish();
	end
endmodule
`default_nettype wire
